// file: hw/bpbc_unit.v
/*
 * breakpoint table and break condition gating for a processor emulator.
 * assumes: apb master on pclk; a target memory port that answers each held
 * request with a one-cycle mem_ack; trap, rom-write and trace restart inputs from
 * logic on pclk; analyzer trigger inputs come from pins and are synchronised.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bpbc_regs.vh"

// Contract
// - trap number 0..0fh selects trap opcode
// - setting breakpoint saves opcode, plants trap
// - any trap breaks; table says planted or not
// - planted trap restores original opcode
// - user trap reported undefined; host resumes vector
// - new trap number disables all entries
// - global enable leaves entry states unchanged
// - query returns entries, states, global flag
// - hit entry becomes disabled, stays defined
// - enable one address or all entries
// - disable one address, keep entry
// - remove deletes entry from table
// - global off disables all, keeps entries
// - rom write with condition enabled breaks
// - rom write never modifies; no break if disabled
// - each analyzer routed to line one or two
// - enabled line assertion breaks, reports line
// - trigger break may lag several cycles
// - causing line released after break
// - other line held until trace halt/start
module bpbc_unit (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // target memory port for planting and restoring opcodes
    output reg         mem_req,
    output reg         mem_we,
    output reg  [23:0] mem_addr,
    output reg  [15:0] mem_wdata,
    input  wire [15:0] mem_rdata,
    input  wire        mem_ack,
    // emulated processor events
    input  wire        trap_taken,
    input  wire [23:0] trap_addr,
    input  wire        bus_write,
    input  wire        bus_rom_hit,
    output wire        bus_write_inhibit,
    // analyzers
    input  wire        emu_trigger,
    input  wire        ext_trigger,
    input  wire        trace_restart,
    output wire        internal_line_one,
    output wire        internal_line_two,
    // monitor
    output reg         break_req,
    input  wire        in_monitor
);

// ************************************************************
// state and storage
// ************************************************************
localparam ST_IDLE  = 4'b0001;
localparam ST_READ  = 4'b0010;
localparam ST_WRITE = 4'b0100;
localparam ST_DONE  = 4'b1000;

reg  [3:0]               state;
reg  [3:0]               trap_num;
reg                      bp_enable;
reg                      rom_break_en;
reg                      line1_break_en;
reg                      line2_break_en;
reg                      emu_sel;
reg                      ext_sel;
reg  [2:0]               cause;
reg  [`BPBC_IDX_W-1:0]   qsel;
reg  [`BPBC_IDX_W-1:0]   cur_idx;
reg                      restore_pend;
reg  [`BPBC_IDX_W-1:0]   restore_idx;
reg  [`BPBC_ENTRIES-1:0] defined;
reg  [`BPBC_ENTRIES-1:0] armed;
reg  [23:0]              bp_addr [0:`BPBC_ENTRIES-1];
reg  [15:0]              bp_orig [0:`BPBC_ENTRIES-1];
reg  [1:0]               emu_sync;
reg  [1:0]               ext_sync;
reg                      line1_hold;
reg                      line2_hold;

wire wr_en = psel & penable & pwrite;
wire [3:0] cmd_op = pwdata[`BPBC_OP_HI:`BPBC_OP_LO];
wire [23:0] cmd_addr = pwdata[`BPBC_ADDR_W-1:0];
wire busy = (state != ST_IDLE);

// ************************************************************
// address match and free slot search
// ************************************************************
reg  [`BPBC_ENTRIES-1:0] cmd_hit;
reg  [`BPBC_ENTRIES-1:0] trap_hit;
genvar g;
generate
    for (g = 0; g < `BPBC_ENTRIES; g = g + 1) begin : g_match
        always @* begin
            cmd_hit[g] = defined[g] & (bp_addr[g] == cmd_addr);
            trap_hit[g] = defined[g] & armed[g] & (bp_addr[g] == trap_addr);
        end
    end
endgenerate

reg                    free_ok;
reg [`BPBC_IDX_W-1:0]  free_idx;
reg                    tmatch_ok;
reg [`BPBC_IDX_W-1:0]  tmatch_idx;
integer i;
always @* begin
    free_ok = 1'b0;
    free_idx = {`BPBC_IDX_W{1'b0}};
    tmatch_ok = 1'b0;
    tmatch_idx = {`BPBC_IDX_W{1'b0}};
    for (i = `BPBC_ENTRIES - 1; i >= 0; i = i - 1) begin
        if (!defined[i]) begin
            free_ok = 1'b1;
            free_idx = i[`BPBC_IDX_W-1:0];
        end
        if (trap_hit[i]) begin
            tmatch_ok = 1'b1;
            tmatch_idx = i[`BPBC_IDX_W-1:0];
        end
    end
end

// ************************************************************
// apb slave
// ************************************************************
// zero wait states: every access completes in its first access cycle
assign pready = 1'b1;
assign pslverr = 1'b0;

reg  [31:0]              rd_mux;
always @* begin
    case (paddr)
        `BPBC_CTRL_OFS:  rd_mux = {22'h0, ext_sel, emu_sel, line2_break_en,
                                   line1_break_en, rom_break_en, bp_enable, trap_num};
        `BPBC_STAT_OFS:  rd_mux = {12'h0, busy, cause, defined, armed};
        `BPBC_QSEL_OFS:  rd_mux = {29'h0, qsel};
        `BPBC_QDATA_OFS: rd_mux = {6'h0, defined[qsel], armed[qsel], bp_addr[qsel]};
        `BPBC_TRAP_OFS:  rd_mux = {16'h0, `BPBC_TRAP_BASE | {12'h0, trap_num}};
        default:         rd_mux = 32'h0;
    endcase
end

// read data is caught in the setup cycle so that it stands as a flop output
// through the whole access phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
        prdata <= rd_mux;
end

// ************************************************************
// control, table and memory sequencer
// ************************************************************
// a restore that could not start at once is taken from the pending slot
wire [`BPBC_IDX_W-1:0] restore_sel = restore_pend ? restore_idx : tmatch_idx;
wire                   restore_go  = restore_pend | (trap_taken & tmatch_ok);

reg [`BPBC_ENTRIES-1:0] next_armed;
always @* begin
    next_armed = armed;
    if (wr_en && paddr == `BPBC_CTRL_OFS) begin
        if (pwdata[`BPBC_CTRL_TRAPN_HI:`BPBC_CTRL_TRAPN_LO] != trap_num)
            next_armed = {`BPBC_ENTRIES{1'b0}};
        if (!pwdata[`BPBC_CTRL_BPEN])
            next_armed = {`BPBC_ENTRIES{1'b0}};
    end
    if (wr_en && paddr == `BPBC_CMD_OFS && !busy) begin
        case (cmd_op)
            `BPBC_OP_EN:     next_armed = armed | (cmd_hit & {`BPBC_ENTRIES{bp_enable}});
            `BPBC_OP_EN_ALL: next_armed = defined & {`BPBC_ENTRIES{bp_enable}};
            `BPBC_OP_DIS:    next_armed = armed & ~cmd_hit;
            `BPBC_OP_REMOVE: next_armed = armed & ~cmd_hit;
            default:         next_armed = next_armed;
        endcase
    end
    // a hit disarms at once, even when its restore has to wait its turn
    if (trap_taken && tmatch_ok)
        next_armed[tmatch_idx] = 1'b0;
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state <= ST_IDLE;
        trap_num <= 4'h0;
        bp_enable <= 1'b0;
        rom_break_en <= 1'b0;
        line1_break_en <= 1'b0;
        line2_break_en <= 1'b0;
        emu_sel <= 1'b0;
        ext_sel <= 1'b0;
        qsel <= {`BPBC_IDX_W{1'b0}};
        defined <= {`BPBC_ENTRIES{1'b0}};
        armed <= {`BPBC_ENTRIES{1'b0}};
        cur_idx <= {`BPBC_IDX_W{1'b0}};
        restore_pend <= 1'b0;
        restore_idx <= {`BPBC_IDX_W{1'b0}};
        mem_req <= 1'b0;
        mem_we <= 1'b0;
        mem_addr <= 24'h0;
        mem_wdata <= 16'h0;
    end else begin
        armed <= next_armed;
        if (wr_en && paddr == `BPBC_CTRL_OFS) begin
            trap_num <= pwdata[`BPBC_CTRL_TRAPN_HI:`BPBC_CTRL_TRAPN_LO];
            bp_enable <= pwdata[`BPBC_CTRL_BPEN];
            rom_break_en <= pwdata[`BPBC_CTRL_ROMEN];
            line1_break_en <= pwdata[`BPBC_CTRL_L1EN];
            line2_break_en <= pwdata[`BPBC_CTRL_L2EN];
            emu_sel <= pwdata[`BPBC_CTRL_EMU_SEL];
            ext_sel <= pwdata[`BPBC_CTRL_EXT_SEL];
        end
        if (wr_en && paddr == `BPBC_QSEL_OFS)
            qsel <= pwdata[`BPBC_IDX_W-1:0];
        if (wr_en && paddr == `BPBC_CMD_OFS && !busy && cmd_op == `BPBC_OP_REMOVE)
            defined <= defined & ~cmd_hit;
        case (state)
            ST_IDLE: begin
                // a restore goes first; a set in the same cycle is dropped
                if (restore_go) begin
                    cur_idx <= restore_sel;
                    restore_pend <= 1'b0;
                    mem_req <= 1'b1;
                    mem_we <= 1'b1;
                    mem_addr <= bp_addr[restore_sel];
                    mem_wdata <= bp_orig[restore_sel];
                    state <= ST_WRITE;
                end else if (wr_en && paddr == `BPBC_CMD_OFS && cmd_op == `BPBC_OP_SET
                             && free_ok && cmd_hit == {`BPBC_ENTRIES{1'b0}}) begin
                    cur_idx <= free_idx;
                    bp_addr[free_idx] <= cmd_addr;
                    defined[free_idx] <= 1'b1;
                    mem_req <= 1'b1;
                    mem_we <= 1'b0;
                    mem_addr <= cmd_addr;
                    state <= ST_READ;
                end
            end
            ST_READ: begin
                if (mem_ack) begin
                    bp_orig[cur_idx] <= mem_rdata;
                    mem_we <= 1'b1;
                    mem_wdata <= `BPBC_TRAP_BASE | {12'h0, trap_num};
                    state <= ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (mem_ack) begin
                    mem_req <= 1'b0;
                    mem_we <= 1'b0;
                    state <= ST_DONE;
                end
            end
            ST_DONE: begin
                state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
        endcase
        // a planted trap hit while the sequencer is busy waits for idle
        if ((state != ST_IDLE || restore_pend) && trap_taken && tmatch_ok) begin
            restore_pend <= 1'b1;
            restore_idx <= tmatch_idx;
        end
    end
end

// ************************************************************
// break conditions and trigger lines
// ************************************************************
assign bus_write_inhibit = bus_write & bus_rom_hit;
wire rom_event = bus_write & bus_rom_hit & rom_break_en & !in_monitor;
wire emu_trig_s = emu_sync[1];
wire ext_trig_s = ext_sync[1];

assign internal_line_one = line1_hold;
assign internal_line_two = line2_hold;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        emu_sync <= 2'b00;
        ext_sync <= 2'b00;
        line1_hold <= 1'b0;
        line2_hold <= 1'b0;
        break_req <= 1'b0;
        cause <= `BPBC_CAUSE_NONE;
    end else begin
        emu_sync <= {emu_sync[0], emu_trigger};
        ext_sync <= {ext_sync[0], ext_trigger};
        // a trigger in the cycle of a restart belongs to the new trace: set wins
        if (trace_restart) begin
            line1_hold <= 1'b0;
            line2_hold <= 1'b0;
        end
        if ((emu_trig_s & !emu_sel) | (ext_trig_s & !ext_sel))
            line1_hold <= 1'b1;
        if ((emu_trig_s & emu_sel) | (ext_trig_s & ext_sel))
            line2_hold <= 1'b1;
        // the line that caused the break is let go even while its trigger stays up
        if (in_monitor && cause == `BPBC_CAUSE_LINE1)
            line1_hold <= 1'b0;
        if (in_monitor && cause == `BPBC_CAUSE_LINE2)
            line2_hold <= 1'b0;
        if (in_monitor)
            break_req <= 1'b0;
        else if (!break_req) begin
            if (trap_taken) begin
                break_req <= 1'b1;
                cause <= tmatch_ok ? `BPBC_CAUSE_PLANTED : `BPBC_CAUSE_UNDEF;
            end else if (rom_event) begin
                break_req <= 1'b1;
                cause <= `BPBC_CAUSE_ROM;
            end else if (line1_hold && line1_break_en) begin
                break_req <= 1'b1;
                cause <= `BPBC_CAUSE_LINE1;
            end else if (line2_hold && line2_break_en) begin
                break_req <= 1'b1;
                cause <= `BPBC_CAUSE_LINE2;
            end
        end
    end
end

endmodule // bpbc_unit
`default_nettype wire

// file: hw/bpbc_regs.vh
/*
 * register map, field positions and codes of the breakpoint and break
 * condition unit. assumes a 32-bit apb slave with word-aligned registers.
 */
`ifndef BPBC_REGS_VH
`define BPBC_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define BPBC_CTRL_OFS      12'h000
`define BPBC_STAT_OFS      12'h004
`define BPBC_CMD_OFS       12'h008
`define BPBC_QSEL_OFS      12'h00c
`define BPBC_QDATA_OFS     12'h010
`define BPBC_TRAP_OFS      12'h014

// ************************************************************
// control register fields
// ************************************************************
`define BPBC_CTRL_TRAPN_LO 0
`define BPBC_CTRL_TRAPN_HI 3
`define BPBC_CTRL_BPEN     4
`define BPBC_CTRL_ROMEN    5
`define BPBC_CTRL_L1EN     6
`define BPBC_CTRL_L2EN     7
`define BPBC_CTRL_EMU_SEL  8
`define BPBC_CTRL_EXT_SEL  9
`define BPBC_CTRL_MASK     32'h0000_03ff

// ************************************************************
// command register: op in [31:28], address in [23:0]
// ************************************************************
`define BPBC_OP_LO         28
`define BPBC_OP_HI         31
`define BPBC_OP_SET        4'h1
`define BPBC_OP_EN         4'h2
`define BPBC_OP_EN_ALL     4'h3
`define BPBC_OP_DIS        4'h4
`define BPBC_OP_REMOVE     4'h5
`define BPBC_ADDR_W        24

// ************************************************************
// break cause codes
// ************************************************************
`define BPBC_CAUSE_NONE    3'h0
`define BPBC_CAUSE_PLANTED 3'h1
`define BPBC_CAUSE_UNDEF   3'h2
`define BPBC_CAUSE_ROM     3'h3
`define BPBC_CAUSE_LINE1   3'h4
`define BPBC_CAUSE_LINE2   3'h5

// ************************************************************
// table and opcode constants
// ************************************************************
`define BPBC_ENTRIES       8
`define BPBC_IDX_W         3
`define BPBC_TRAP_BASE     16'h4e40
`define BPBC_TRAP_NUM_MAX  4'hf

`endif

// file: testbench/bpbc_mem_model.sv
/* opcode memory on the far side of the planting port of bpbc_unit.
   assumes one request at a time, held until acknowledged. */
`timescale 1ns/1ns
`default_nettype none
module bpbc_mem_model (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // request
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [1:0]  lag,
    // answer
    output logic     [15:0] mem_rdata,
    output logic            mem_ack
);
    logic [15:0] mem [0:255];
    logic [1:0]  cnt;
    initial for (int i = 0; i < 256; i++) mem[i] = 16'h2000 | 16'(i);
    // lag gives prompt or slow answers; data toggles outside an answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= '0;
            cnt <= '0;
            mem_rdata <= '0;
        end else begin
            mem_ack <= '0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (cnt == lag) begin
                    mem_ack <= 1'b1;
                    cnt <= '0;
                    mem_rdata <= mem[mem_addr[7:0]];
                    if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
                end else cnt <= cnt + 2'h1;
            end
        end
    end
endmodule // bpbc_mem_model
`default_nettype wire

// file: testbench/bpbc_unit_assertions.sv
/* port checker of bpbc_unit.
   assumes one clock domain with asynchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module bpbc_unit_assertions (
    // clock and memory port
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic        mem_ack,
    // events and outputs
    input wire logic        trap_taken,
    input wire logic        bus_write,
    input wire logic        bus_rom_hit,
    input wire logic        bus_write_inhibit,
    input wire logic        emu_trigger,
    input wire logic        ext_trigger,
    input wire logic        trace_restart,
    input wire logic        internal_line_one,
    input wire logic        internal_line_two,
    input wire logic        break_req,
    input wire logic        in_monitor
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_quiet;
        (!in_monitor && !trace_restart)[*2];
    endsequence
    sequence s_mem_wait;
        mem_req && !mem_ack;
    endsequence
    a_mem_hold: assert property (s_mem_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before answer");
    a_mem_single: assert property (mem_req && mem_we && mem_ack |=> !mem_req)
        else $error("memory request kept after write");
    a_rom_inhibit: assert property (bus_write_inhibit == (bus_write && bus_rom_hit))
        else $error("rom write not suppressed");
    a_trap_break: assert property (trap_taken && !in_monitor && !break_req |=> break_req)
        else $error("trap did not break");
    a_break_hold: assert property (break_req && !in_monitor |=> break_req)
        else $error("break dropped before monitor");
    a_break_clear: assert property (break_req && in_monitor |-> ##[1:2] !break_req)
        else $error("break kept in monitor");
    a_trig_line: assert property ($rose(emu_trigger) |-> ##[1:5] (internal_line_one || internal_line_two))
        else $error("trigger reached no line");
    a_line_sticky: assert property (s_quiet ##0 internal_line_one |=> internal_line_one)
        else $error("line one dropped while tracing");
    a_restart_clear: assert property (trace_restart && !$past(emu_trigger, 2) && !$past(ext_trigger, 2) |=> !internal_line_one && !internal_line_two)
        else $error("lines kept after restart");
endmodule // bpbc_unit_assertions
bind bpbc_unit bpbc_unit_assertions bpbc_unit_assertions_inst (.*);
`default_nettype wire

// file: testbench/tb_bpbc_unit.sv
/* self-checking bench of bpbc_unit with the memory model on its opcode port.
   assumes the apb answer comes in the access cycle and table slots fill in order. */
`timescale 1ns/1ns
`default_nettype none
`include "bpbc_regs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_bpbc_unit;
    logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, mem_req, mem_we, mem_ack, bus_write_inhibit, break_req;
    logic [23:0] mem_addr, trap_addr = '0, a0, a1;
    logic [15:0] mem_wdata, mem_rdata;
    logic        trap_taken = '0, bus_write = '0, bus_rom_hit = '0, emu_trigger = '0;
    logic        ext_trigger = '0, trace_restart = '0, in_monitor = '0;
    logic        internal_line_one, internal_line_two;
    logic [1:0]  lag = '0;
    logic [3:0]  tn;
    logic [39:0] e, exp_q[$];
    int          err_count = 0, num_checks = 0, cyc = 0;
    bpbc_unit bpbc_unit_inst (.*);
    bpbc_mem_model bpbc_mem_model_inst (.*);
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end
    // every acknowledged memory write is matched against the oldest note
    always @(posedge pclk) if (mem_req && mem_we && mem_ack) begin
        e = exp_q.size() ? exp_q.pop_front() : 'x;
        `CHK("mem_write", e, {mem_addr, mem_wdata})
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] m, x, input string n);
        apb(1'b0, a, '0);
        `CHK(n, x, rd & m)
    endtask
    task automatic cmd(input logic [3:0] op, input logic [23:0] a);
        lag <= 2'($urandom % 3);
        apb(1'b1, `BPBC_CMD_OFS, {op, 4'h0, a});
        do apb(1'b0, `BPBC_STAT_OFS, '0); while (rd[19] !== 1'b0);
    endtask
    task automatic brk(input logic [2:0] c);
        for (int n = 0; n < 20 && break_req !== 1'b1; n++) @(posedge pclk);
        `CHK("break_req", 1'b1, break_req)
        rc(`BPBC_STAT_OFS, 32'h70000, {13'h0, c, 16'h0}, "cause");
        in_monitor <= 1'b1;
        repeat (3) @(posedge pclk);
        in_monitor <= 1'b0;
    endtask
    // one-cycle pulse on trap_taken (t=1) or trace_restart (t=0)
    task automatic pulse(input logic t);
        @(posedge pclk);
        if (t) trap_taken <= 1'b1;
        else trace_restart <= 1'b1;
        @(posedge pclk);
        trap_taken <= 1'b0;
        trace_restart <= 1'b0;
    endtask
    initial begin
        void'($urandom(78554));
        tn = 4'($urandom);
        a0 = {16'h0, 8'($urandom)};
        a1 = a0 ^ 24'h55;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rc(`BPBC_STAT_OFS, '1, '0, "stat_reset");
        rc(12'h0fc, '1, '0, "unmapped");
        apb(1'b1, `BPBC_CTRL_OFS, 32'h10 | tn);
        rc(`BPBC_TRAP_OFS, '1, `BPBC_TRAP_BASE | tn, "trap_op");
        rc(`BPBC_CTRL_OFS, '1, 32'h10 | tn, "global_flag");
        exp_q.push_back({a0, `BPBC_TRAP_BASE | 16'(tn)});
        cmd(`BPBC_OP_SET, a0);
        exp_q.push_back({a1, `BPBC_TRAP_BASE | 16'(tn)});
        cmd(`BPBC_OP_SET, a1);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0300, "new_disarmed");
        apb(1'b1, `BPBC_QSEL_OFS, '0);
        rc(`BPBC_QDATA_OFS, '1, {8'h2, a0}, "query");
        cmd(`BPBC_OP_EN, a0);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0301, "enable_one");
        exp_q.push_back({a0, 16'h2000 | 16'(a0[7:0])});
        trap_addr <= a0;
        pulse(1'b1);
        brk(`BPBC_CAUSE_PLANTED);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0300, "hit_disarms");
        trap_addr <= a0 ^ 24'h0f0f00;
        pulse(1'b1);
        brk(`BPBC_CAUSE_UNDEF);
        cmd(`BPBC_OP_EN_ALL, '0);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0303, "enable_all");
        cmd(`BPBC_OP_DIS, a0);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0302, "disable");
        cmd(`BPBC_OP_REMOVE, a1);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0100, "remove");
        cmd(`BPBC_OP_EN, a0);
        tn = ~tn;
        apb(1'b1, `BPBC_CTRL_OFS, 32'h10 | tn);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0100, "trap_change");
        cmd(`BPBC_OP_EN, a0);
        apb(1'b1, `BPBC_CTRL_OFS, 32'h00 | tn);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0100, "global_off");
        apb(1'b1, `BPBC_CTRL_OFS, 32'h10 | tn);
        rc(`BPBC_STAT_OFS, 32'hffff, 32'h0100, "global_on");
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `BPBC_CTRL_OFS, (i ? 32'h10 : 32'h30) | tn);
            @(posedge pclk);
            bus_write <= 1'b1;
            bus_rom_hit <= 1'b1;
            @(negedge pclk);
            `CHK("inhibit", 1'b1, bus_write_inhibit)
            @(posedge pclk);
            bus_write <= 1'b0;
            if (i == 0) brk(`BPBC_CAUSE_ROM);
            else repeat (6) @(posedge pclk);
            if (i) `CHK("no_rom_break", 1'b0, break_req)
        end
        bus_rom_hit <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `BPBC_CTRL_OFS, (i ? 32'h250 : 32'h190) | tn);
            @(posedge pclk);
            emu_trigger <= 1'b1;
            ext_trigger <= 1'b1;
            repeat (3) @(posedge pclk);
            emu_trigger <= 1'b0;
            ext_trigger <= 1'b0;
            brk(i ? `BPBC_CAUSE_LINE1 : `BPBC_CAUSE_LINE2);
            `CHK("lines", i ? 2'b10 : 2'b01, {internal_line_two, internal_line_one})
            pulse(1'b0);
            @(negedge pclk);
            `CHK("lines_restart", 2'b00, {internal_line_two, internal_line_one})
        end
        `CHK("queue_left", 0, exp_q.size())
        stop_test();
    end
endmodule // tb_bpbc_unit
`default_nettype wire
